// *** shared/cic_pkg.sv ***
// Constants of the core interrupt control block.
// Assumes a 100 MHz core clock and a classic Wishbone register bus.
//
// Operation
// RULE_01 - Any reset leaves the global enable clear, so no redirection.
// RULE_02 - Redirect needs global and own enable, plus group for peripherals.
// RULE_03 - Events live as flags in core control and two peripheral flag regs.
// RULE_04 - A flag sets on its event whatever the state of any enable.
// RULE_05 - Entry: flush, clear enable, push PC, save context, jump to 0004h.
// RULE_06 - With global enable clear, flags latch and wait until it is set.
// RULE_07 - Return pops the address, restores context, sets global enable.
// RULE_08 - A set, enabled flag at return is a live request and re-enters.
// RULE_09 - Firmware polls flags to find the source, as there is one vector.
// RULE_10 - Enabled sources wake the core from sleep.
// RULE_11 - Event to handler start takes three or four instruction cycles.
// RULE_12 - Pin flag sets on rising edge if edge select set, else on falling.
// RULE_13 - Wake runs one instruction, then vectors only with global enable.
// RULE_14 - Saved: W, status less timeout/powerdown, bank, file sel, PC high.
// RULE_15 - Redirect at a boundary: global enable AND any fully enabled flag.
package cic_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CIC_OFS_CORE_CTRL = 8'h00;
    localparam logic [7:0] CIC_OFS_PEN_A = 8'h04;
    localparam logic [7:0] CIC_OFS_PEN_B = 8'h08;
    localparam logic [7:0] CIC_OFS_PFLAG_A = 8'h0C;
    localparam logic [7:0] CIC_OFS_PFLAG_B = 8'h10;
    localparam logic [7:0] CIC_OFS_CONFIG = 8'h14;
    localparam logic [7:0] CIC_OFS_STATE = 8'h18;
    localparam logic [7:0] CIC_OFS_EVT_STATUS = 8'h1C;
    localparam logic [7:0] CIC_OFS_EVT_CLEAR = 8'h20;
    localparam logic [7:0] CIC_OFS_EVT_ENABLE = 8'h24;
    // ------------------------------------------------------------
    // Core control and config register fields
    // ------------------------------------------------------------
    localparam int CIC_BIT_GLOBAL_EN = 7;
    localparam int CIC_BIT_GROUP_EN = 6;
    localparam int CIC_BIT_TMR_IE = 5;
    localparam int CIC_BIT_EXT_IE = 4;
    localparam int CIC_BIT_IOC_IE = 3;
    localparam int CIC_BIT_TMR_IF = 2;
    localparam int CIC_BIT_EXT_IF = 1;
    localparam int CIC_BIT_IOC_IF = 0;
    localparam int CIC_BIT_EDGE_SEL = 0;
    // ------------------------------------------------------------
    // Event status bits
    // ------------------------------------------------------------
    localparam int CIC_EVT_ENTRY = 0;
    localparam int CIC_EVT_RETURN = 1;
    localparam int CIC_EVT_WAKE = 2;
    localparam int CIC_EVT_W = 3;
    // ------------------------------------------------------------
    // Reset values and vector
    // ------------------------------------------------------------
    localparam logic [7:0] CIC_RST_CTRL = 8'h00;
    localparam logic [7:0] CIC_RST_PEN = 8'h00;
    localparam logic CIC_RST_EDGE_SEL = 1'b1;
    localparam logic [14:0] CIC_VECTOR = 15'h0004;
    localparam logic [31:0] CIC_RD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        CIC_WAKE_RUN,
        CIC_WAKE_SLEEP,
        CIC_WAKE_STEP
    } cic_wake_t;
endpackage : cic_pkg

// *** logic/cic_flag_bank.sv ***
// Bank of event flags with software write.
// Assumes events and writes are synchronous to the core clock.
`timescale 1ns/1ns
`default_nettype none
module cic_flag_bank #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Events and software write
    input wire logic [W-1:0] evt_in,
    input wire logic wr_in,
    input wire logic [W-1:0] wdata_in,
    // Flags
    output logic [W-1:0] flag_out
);
    // Set wins over a clear in the same cycle, so no event is lost
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_out <= '0;
        end else if (wr_in) begin
            flag_out <= wdata_in | evt_in; // RULE_04
        end else begin
            flag_out <= flag_out | evt_in; // RULE_03
        end
    end
endmodule : cic_flag_bank
`default_nettype wire

// *** logic/cic_core.sv ***
// Core interrupt control: flags, enables, entry, return and wake.
// Assumes a sequencer that pulses boundary and return at instruction
// boundaries and does the flush, push and fetch on redirect.
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module cic_core (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Event sources
    input wire logic tmr_evt_in,
    input wire logic ext_pin_in,
    input wire logic ioc_any_in,
    input wire logic [7:0] periph_evt_a_in,
    input wire logic [7:0] periph_evt_b_in,
    // Sequencer
    input wire logic boundary_in,
    input wire logic return_in,
    input wire logic sleep_in,
    input wire logic [14:0] pc_in,
    output logic redirect_out,
    output logic [14:0] vector_out,
    output logic [14:0] push_pc_out,
    output logic restore_out,
    output logic wake_out,
    // Context
    input wire logic [7:0] ctx_w_in,
    input wire logic [2:0] ctx_status_in,
    input wire logic [4:0] ctx_bank_sel_in,
    input wire logic [15:0] ctx_file_sel0_in,
    input wire logic [15:0] ctx_file_sel1_in,
    input wire logic [6:0] ctx_pc_high_in,
    output logic [7:0] shadow_w_out,
    output logic [2:0] shadow_status_out,
    output logic [4:0] shadow_bank_sel_out,
    output logic [15:0] shadow_file_sel0_out,
    output logic [15:0] shadow_file_sel1_out,
    output logic [6:0] shadow_pc_high_out,
    // System interrupt
    output logic irq_out
);
    import cic_pkg::*;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic bus_req;
    logic wr_lane;
    logic wr_ctrl;
    logic wr_pen_a;
    logic wr_pen_b;
    logic wr_pflag_a;
    logic wr_pflag_b;
    logic wr_config;
    logic wr_clear;
    logic wr_evt_en;
    assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    // Registers are 8 bits wide and sit in the low byte lane
    assign wr_lane = bus_req && wb_we_in && wb_sel_in[0];
    assign wr_ctrl = wr_lane && (wb_adr_in == CIC_OFS_CORE_CTRL);
    assign wr_pen_a = wr_lane && (wb_adr_in == CIC_OFS_PEN_A);
    assign wr_pen_b = wr_lane && (wb_adr_in == CIC_OFS_PEN_B);
    assign wr_pflag_a = wr_lane && (wb_adr_in == CIC_OFS_PFLAG_A);
    assign wr_pflag_b = wr_lane && (wb_adr_in == CIC_OFS_PFLAG_B);
    assign wr_config = wr_lane && (wb_adr_in == CIC_OFS_CONFIG);
    assign wr_clear = wr_lane && (wb_adr_in == CIC_OFS_EVT_CLEAR);
    assign wr_evt_en = wr_lane && (wb_adr_in == CIC_OFS_EVT_ENABLE);

    // ------------------------------------------------------------
    // Enables and configuration
    // ------------------------------------------------------------
    logic global_irq_enable;
    logic peripheral_group_irq_enable;
    logic [2:0] core_en;
    logic [7:0] pen_a;
    logic [7:0] pen_b;
    logic ext_pin_edge_select;
    logic [CIC_EVT_W-1:0] evt_en;
    logic take_irq;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            global_irq_enable <= CIC_RST_CTRL[CIC_BIT_GLOBAL_EN]; // RULE_01
        end else if (take_irq) begin
            global_irq_enable <= 1'b0; // RULE_05
        end else if (return_in) begin
            global_irq_enable <= 1'b1; // RULE_07
        end else if (wr_ctrl) begin
            global_irq_enable <= wb_dat_in[CIC_BIT_GLOBAL_EN];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            peripheral_group_irq_enable <= CIC_RST_CTRL[CIC_BIT_GROUP_EN];
            core_en <= CIC_RST_CTRL[CIC_BIT_TMR_IE:CIC_BIT_IOC_IE];
            pen_a <= CIC_RST_PEN;
            pen_b <= CIC_RST_PEN;
            ext_pin_edge_select <= CIC_RST_EDGE_SEL;
            evt_en <= '0;
        end else begin
            if (wr_ctrl) begin
                peripheral_group_irq_enable <= wb_dat_in[CIC_BIT_GROUP_EN];
                core_en <= wb_dat_in[CIC_BIT_TMR_IE:CIC_BIT_IOC_IE];
            end
            if (wr_pen_a) begin
                pen_a <= wb_dat_in[7:0];
            end
            if (wr_pen_b) begin
                pen_b <= wb_dat_in[7:0];
            end
            if (wr_config) begin
                ext_pin_edge_select <= wb_dat_in[CIC_BIT_EDGE_SEL];
            end
            if (wr_evt_en) begin
                evt_en <= wb_dat_in[CIC_EVT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Source flags
    // ------------------------------------------------------------
    logic ext_prev;
    logic ext_edge;
    logic [1:0] core_flag;
    logic [7:0] pflag_a;
    logic [7:0] pflag_b;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_pin_in;
        end
    end
    assign ext_edge = ext_pin_edge_select ? (ext_pin_in && !ext_prev)
        : (!ext_pin_in && ext_prev); // RULE_12

    cic_flag_bank #(.W(2)) u_core_flags (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .evt_in({tmr_evt_in, ext_edge}),
        .wr_in(wr_ctrl),
        .wdata_in(wb_dat_in[CIC_BIT_TMR_IF:CIC_BIT_EXT_IF]),
        .flag_out(core_flag)
    );
    cic_flag_bank #(.W(8)) u_pflag_a (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .evt_in(periph_evt_a_in),
        .wr_in(wr_pflag_a),
        .wdata_in(wb_dat_in[7:0]),
        .flag_out(pflag_a)
    );
    cic_flag_bank #(.W(8)) u_pflag_b (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .evt_in(periph_evt_b_in),
        .wr_in(wr_pflag_b),
        .wdata_in(wb_dat_in[7:0]),
        .flag_out(pflag_b)
    );

    // ------------------------------------------------------------
    // Request and wake
    // ------------------------------------------------------------
    logic core_hit;
    logic periph_hit;
    logic src_hit;
    logic pend;
    cic_wake_t wake_state;
    assign core_hit = |({core_flag, ioc_any_in} & core_en); // RULE_02
    assign periph_hit = peripheral_group_irq_enable
                        && |((pflag_a & pen_a) | (pflag_b & pen_b));
    assign src_hit = core_hit || periph_hit;
    // Flags keep their request while the global enable is clear
    assign pend = global_irq_enable && src_hit; // RULE_06 RULE_08
    // Return wins a shared boundary, the request is seen at the next
    assign take_irq = boundary_in && pend && !return_in && !sleep_in
                      && (wake_state == CIC_WAKE_RUN); // RULE_15
    assign wake_out = sleep_in && src_hit; // RULE_10

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake_state <= CIC_WAKE_RUN;
        end else begin
            case (wake_state)
                CIC_WAKE_RUN: begin
                    if (sleep_in) begin
                        wake_state <= CIC_WAKE_SLEEP;
                    end
                end
                CIC_WAKE_SLEEP: begin
                    if (!sleep_in) begin
                        wake_state <= CIC_WAKE_STEP;
                    end
                end
                CIC_WAKE_STEP: begin
                    // One instruction runs before any vectoring
                    if (boundary_in) begin
                        wake_state <= CIC_WAKE_RUN; // RULE_13
                    end
                end
                default: begin
                    wake_state <= CIC_WAKE_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Entry, return and context
    // ------------------------------------------------------------
    assign vector_out = CIC_VECTOR; // RULE_05
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            redirect_out <= 1'b0;
            restore_out <= 1'b0;
            push_pc_out <= '0;
        end else begin
            redirect_out <= take_irq; // RULE_11
            restore_out <= return_in; // RULE_07
            if (take_irq) begin
                push_pc_out <= pc_in; // RULE_05
            end
        end
    end

    // Status timeout and powerdown bits are left out of the copy
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shadow_w_out <= '0;
            shadow_status_out <= '0;
            shadow_bank_sel_out <= '0;
            shadow_file_sel0_out <= '0;
            shadow_file_sel1_out <= '0;
            shadow_pc_high_out <= '0;
        end else if (take_irq) begin
            shadow_w_out <= ctx_w_in; // RULE_14
            shadow_status_out <= ctx_status_in;
            shadow_bank_sel_out <= ctx_bank_sel_in;
            shadow_file_sel0_out <= ctx_file_sel0_in;
            shadow_file_sel1_out <= ctx_file_sel1_in;
            shadow_pc_high_out <= ctx_pc_high_in;
        end
    end

    // ------------------------------------------------------------
    // Event status and interrupt line
    // ------------------------------------------------------------
    logic [CIC_EVT_W-1:0] evt_set;
    logic [CIC_EVT_W-1:0] evt_status;
    assign evt_set = {wake_out, return_in, take_irq};
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            evt_status <= '0;
        end else if (wr_clear) begin
            evt_status <= (evt_status & ~wb_dat_in[CIC_EVT_W-1:0]) | evt_set;
        end else begin
            evt_status <= evt_status | evt_set;
        end
    end
    assign irq_out = |(evt_status & evt_en);

    // ------------------------------------------------------------
    // Read data and acknowledge
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb begin
        case (wb_adr_in)
            CIC_OFS_CORE_CTRL: begin
                rd_byte = {global_irq_enable, peripheral_group_irq_enable,
                           core_en, core_flag, ioc_any_in}; // RULE_03
            end
            CIC_OFS_PEN_A: rd_byte = pen_a;
            CIC_OFS_PEN_B: rd_byte = pen_b;
            CIC_OFS_PFLAG_A: rd_byte = pflag_a;
            CIC_OFS_PFLAG_B: rd_byte = pflag_b;
            CIC_OFS_CONFIG: rd_byte = {7'h00, ext_pin_edge_select};
            CIC_OFS_STATE: rd_byte = {5'h00, pend, wake_state};
            CIC_OFS_EVT_STATUS: rd_byte = {5'h00, evt_status};
            CIC_OFS_EVT_ENABLE: rd_byte = {5'h00, evt_en};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= CIC_RD_ZERO;
        end else begin
            wb_ack_out <= bus_req;
            wb_dat_out <= bus_req ? {24'h00_0000, rd_byte} : CIC_RD_ZERO;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    a_entry_needs_enable: assert property ( // RULE_02
        redirect_out |-> $past(global_irq_enable) && $past(src_hit))
        else $error("redirect without enabled request");
    a_entry_clears_enable: assert property ( // RULE_05
        redirect_out |-> !global_irq_enable)
        else $error("global enable still set after entry");
    a_entry_push_pc: assert property ( // RULE_05
        redirect_out |-> push_pc_out == $past(pc_in))
        else $error("pushed PC wrong");
    a_flag_sets_evt: assert property ( // RULE_04
        periph_evt_a_in[0] |=> pflag_a[0])
        else $error("peripheral flag missed its event");
    a_return_sets_enable: assert property ( // RULE_07
        return_in |=> global_irq_enable && restore_out)
        else $error("return did not restore enable");
    a_shadow_capture: assert property ( // RULE_14
        redirect_out |-> shadow_w_out == $past(ctx_w_in)
            && shadow_file_sel1_out == $past(ctx_file_sel1_in))
        else $error("context not saved");
    a_ext_rising: assert property ( // RULE_12
        ext_pin_edge_select && ext_pin_in && !ext_prev
            |=> core_flag[0])
        else $error("pin edge not flagged");
    a_pending_taken: assert property ( // RULE_06
        boundary_in && pend && !return_in && !sleep_in
            && wake_state == CIC_WAKE_RUN |=> redirect_out)
        else $error("pending request not taken");
    a_wake_step: assert property ( // RULE_13
        wake_state == CIC_WAKE_STEP && boundary_in |=> !redirect_out)
        else $error("vectored before post-wake instruction");
    a_no_entry_disabled: assert property ( // RULE_01
        !global_irq_enable && !return_in |=> !redirect_out)
        else $error("redirect while disabled");

    c_entry: cover property (redirect_out);
    c_reentry: cover property (restore_out ##[1:20] redirect_out);
    c_wake: cover property (wake_state == CIC_WAKE_STEP ##1 boundary_in);
endmodule : cic_core
`default_nettype wire

// *** sim/cic_seq_model.sv ***
// Sequencer model: one instruction boundary every four clocks, one-deep PC
// stack. Assumes the interrupt block answers one clock after a boundary.
`timescale 1ns/1ns
`default_nettype none
module cic_seq_model (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // From interrupt block and bench
    input wire logic redirect_in,
    input wire logic [14:0] vector_in,
    input wire logic ret_req_in,
    // To interrupt block
    output logic boundary_out,
    output logic return_out,
    output logic [14:0] pc_out
);
    logic [1:0] phase;
    logic ret_pend;
    logic [14:0] saved_pc;
    // One level of stack is enough, handlers never nest with entry cleared
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase <= 2'h0;
            ret_pend <= 1'h0;
            boundary_out <= 1'h0;
            return_out <= 1'h0;
            pc_out <= 15'h0000;
            saved_pc <= 15'h0000;
        end else begin
            phase <= phase + 2'h1;
            boundary_out <= (phase == 2'h3);
            return_out <= (phase == 2'h3) && (ret_pend || ret_req_in);
            if (ret_req_in) begin
                ret_pend <= 1'h1;
            end
            if (redirect_in) begin
                saved_pc <= pc_out;
                pc_out <= vector_in;
            end else if (return_out) begin
                pc_out <= saved_pc;
                ret_pend <= 1'h0;
            end else if (boundary_out) begin
                pc_out <= pc_out + 15'h0001;
            end
        end
    end
endmodule : cic_seq_model
`default_nettype wire

// *** sim/core_interrupt_control_bench.sv ***
// Self-checking bench of the interrupt control block.
// Assumes one 100 MHz clock; sequencer comes from the model.
`timescale 1ns/1ns
`default_nettype none
module core_interrupt_control_bench;
    import cic_pkg::*;
    logic clk_sys_in = 1'h0, rst_n_in = 1'h0;
    logic cyc = 1'h0, we = 1'h0, tmr = 1'h0, pin = 1'h0, slp = 1'h0;
    logic ret_req = 1'h0, bnd, rtn, redirect, restore, wake, irq, ack;
    logic [7:0] adr = 8'h00, pa = 8'h00, pb = 8'h00, ea = 8'h00, eb = 8'h00;
    logic [7:0] cw;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic [14:0] pc, vec, ppc, bnd_pc;
    logic [2:0] cst;
    logic [6:0] cpl;
    logic [7:0] sw;
    logic [2:0] sst;
    logic [6:0] spl;
    logic [31:0] exp_q[$];
    int seed, err_total, samples_checked, n_redir, n_rest, cycles;
    always #5 clk_sys_in = ~clk_sys_in;
    cic_core cic_core_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .tmr_evt_in(tmr), .ext_pin_in(pin),
        .ioc_any_in(1'h0), .periph_evt_a_in(ea), .periph_evt_b_in(eb),
        .boundary_in(bnd), .return_in(rtn), .sleep_in(slp), .pc_in(pc),
        .redirect_out(redirect), .vector_out(vec), .push_pc_out(ppc),
        .restore_out(restore), .wake_out(wake), .ctx_w_in(cw),
        .ctx_status_in(cst), .ctx_bank_sel_in(5'h00),
        .ctx_file_sel0_in(16'h0000), .ctx_file_sel1_in(16'h0000),
        .ctx_pc_high_in(cpl), .shadow_w_out(sw), .shadow_status_out(sst),
        .shadow_bank_sel_out(), .shadow_file_sel0_out(),
        .shadow_file_sel1_out(), .shadow_pc_high_out(spl), .irq_out(irq));
    cic_seq_model cic_seq_model_i (.clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in), .redirect_in(redirect), .vector_in(vec),
        .ret_req_in(ret_req), .boundary_out(bnd), .return_out(rtn),
        .pc_out(pc));
    // ----------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    // Read results are noted by the driver and judged here on ack
    always @(posedge clk_sys_in) begin
        if (ack === 1'h1 && !we) begin
            chk("read data", exp_q.size() > 0 ? exp_q.pop_front()
                : 32'hFFFF_FFFF, rdat);
        end
        if (bnd === 1'h1) begin
            bnd_pc <= pc;
        end
        if (redirect === 1'h1) begin
            chk("pushed pc", 32'(bnd_pc), 32'(ppc));
        end
        n_redir <= n_redir + 32'(redirect === 1'h1);
        n_rest <= n_rest + 32'(restore === 1'h1);
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            summarize();
        end
    end
    // ----------------------------------------------------------
    // Bus and sequence tasks
    // ----------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        cyc <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= {24'h00_0000, d};
        // Only the bench cycle ceiling ends a wait for ack
        do begin
            @(posedge clk_sys_in);
        end while (ack !== 1'h1);
        cyc <= 1'h0;
        we <= 1'h0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h00_0000, e});
        wb(1'h0, a, 8'h00);
    endtask : rd
    // Waits a bounded window and compares entries and restores seen
    task automatic expect_evt(input int er, input int es);
        int b, r;
        b = n_redir;
        r = n_rest;
        repeat (24) @(posedge clk_sys_in);
        chk("entries", 32'(er), 32'(n_redir - b));
        chk("restores", 32'(es), 32'(n_rest - r));
    endtask : expect_evt
    task automatic ret();
        @(posedge clk_sys_in);
        ret_req <= 1'h1;
        @(posedge clk_sys_in);
        ret_req <= 1'h0;
    endtask : ret
    task automatic set_pin(input logic v);
        @(posedge clk_sys_in);
        pin <= v;
        repeat (3) @(posedge clk_sys_in);
    endtask : set_pin
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    initial begin
        seed = 22335;
        cw <= 8'($random(seed));
        cst <= 3'($random(seed));
        cpl <= 7'($random(seed));
        repeat (6) @(posedge clk_sys_in);
        rst_n_in <= 1'h1;
        rd(CIC_OFS_CORE_CTRL, 8'h00);
        rd(CIC_OFS_CONFIG, 8'h01);
        rd(8'h30, 8'h00);
        $display("test reset done");
        @(posedge clk_sys_in);
        tmr <= 1'h1;
        ea <= 8'($random(seed)) | 8'h01;
        eb <= 8'($random(seed)) | 8'h80;
        @(posedge clk_sys_in);
        tmr <= 1'h0;
        pa = ea;
        pb = eb;
        ea <= 8'h00;
        eb <= 8'h00;
        rd(CIC_OFS_CORE_CTRL, 8'h04);
        rd(CIC_OFS_PFLAG_A, pa);
        rd(CIC_OFS_PFLAG_B, pb);
        expect_evt(0, 0);
        $display("test flags done");
        wb(1'h1, CIC_OFS_CORE_CTRL, 8'hA4);
        expect_evt(1, 0);
        rd(CIC_OFS_CORE_CTRL, 8'h24);
        chk("vector", 32'(CIC_VECTOR), 32'(vec));
        chk("shadow w", 32'(cw), 32'(sw));
        chk("shadow status", 32'(cst), 32'(sst));
        chk("shadow pc_high_latch", 32'(cpl), 32'(spl));
        chk("irq masked", 32'h0, 32'(irq));
        rd(CIC_OFS_EVT_STATUS, 8'h01);
        wb(1'h1, CIC_OFS_EVT_ENABLE, 8'h01);
        chk("irq raised", 32'h1, 32'(irq));
        wb(1'h1, CIC_OFS_EVT_CLEAR, 8'h07);
        chk("irq cleared", 32'h0, 32'(irq));
        $display("test entry done");
        ret();
        expect_evt(1, 1);
        rd(CIC_OFS_CORE_CTRL, 8'h24);
        wb(1'h1, CIC_OFS_CORE_CTRL, 8'h20);
        ret();
        expect_evt(0, 1);
        rd(CIC_OFS_CORE_CTRL, 8'hA0);
        $display("test return done");
        wb(1'h1, CIC_OFS_PEN_A, pa);
        expect_evt(0, 0);
        wb(1'h1, CIC_OFS_CORE_CTRL, 8'hE0);
        expect_evt(1, 0);
        wb(1'h1, CIC_OFS_PFLAG_A, 8'h00);
        rd(CIC_OFS_PFLAG_A, 8'h00);
        wb(1'h1, CIC_OFS_CORE_CTRL, 8'h00);
        $display("test group done");
        set_pin(1'h1);
        rd(CIC_OFS_CORE_CTRL, 8'h02);
        wb(1'h1, CIC_OFS_CORE_CTRL, 8'h00);
        set_pin(1'h0);
        rd(CIC_OFS_CORE_CTRL, 8'h00);
        wb(1'h1, CIC_OFS_CONFIG, 8'h00);
        set_pin(1'h1);
        rd(CIC_OFS_CORE_CTRL, 8'h00);
        set_pin(1'h0);
        rd(CIC_OFS_CORE_CTRL, 8'h02);
        $display("test pin done");
        wb(1'h1, CIC_OFS_CORE_CTRL, 8'h12);
        chk("wake awake", 32'h0, 32'(wake));
        @(posedge clk_sys_in);
        slp <= 1'h1;
        repeat (2) @(posedge clk_sys_in);
        chk("wake", 32'h1, 32'(wake));
        wb(1'h1, CIC_OFS_CORE_CTRL, 8'h92);
        expect_evt(0, 0);
        slp <= 1'h0;
        expect_evt(1, 0);
        $display("test wake done");
        wb(1'h1, CIC_OFS_CORE_CTRL, 8'h80);
        rst_n_in <= 1'h0;
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'h1;
        rd(CIC_OFS_CORE_CTRL, 8'h00);
        rd(CIC_OFS_CONFIG, 8'h01);
        $display("test reset again done");
        summarize();
    end
endmodule : core_interrupt_control_bench
`default_nettype wire
